// ===== core/monitor_mode_entry_select.sv
/*
 * Monitor/user mode entry decoder with bus clock source selection,
 * watchdog enable and serial pin control.
 * Assumes clk is the oscillator clock, reset_n is power-on reset, pin
 * levels are already digitised (test-voltage detectors give separate
 * flags) and the vector bytes come from same-clock flash read logic.
 */
`timescale 1ns/1ps
module monitor_mode_entry_select
    import monitor_entry_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          resetPinHigh,
    input  wire logic                          resetTestHigh,
    input  wire logic                          irqPinHigh,
    input  wire logic                          irqTestHigh,
    input  wire monitor_entry_pkg::entry_pins_t entryPins,
    input  wire logic [7:0]                    vectorHigh,
    input  wire logic [7:0]                    vectorLow,
    input  wire logic                          pllOutputTick,
    input  wire logic                          serialTxBit,
    output logic                               monitorMode,
    output logic                               serialComm,
    output logic                               pllEnable,
    output logic                               baseClockSelect,
    output logic                               oscBypass,
    output logic                               crystalOscEnable,
    output logic                               busClockEnable,
    output logic                               watchdogEnable,
    output logic                               illegalAddressReset,
    output logic                               serialPinOut,
    output logic                               serialPinOe
);
    import monitor_entry_pkg::*;

    logic [7:0]   syncIn;
    logic [7:0]   syncOut;
    entry_pins_t  pinsSync;
    logic         resetPinSync;
    logic         resetTestSync;
    logic         irqHighSync;
    logic         irqTestSync;
    logic         vectorBlank;

    entry_state_t state_ff;
    entry_state_t nxt_state;
    mode_t        mode_ff;
    mode_t        nxt_mode;
    logic         illegal_ff;
    logic         nxt_illegal;
    logic         wdog_ff;
    logic         nxt_wdog;
    logic         divRun;
    logic         divTickIn;
    logic [2:0]   divRatio;

    assign syncIn = {entryPins, resetPinHigh, resetTestHigh, irqPinHigh, irqTestHigh};

    pin_sync #(
        .WIDTH   (8)
    ) u_pin_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pinIn   (syncIn),
        .pinSync (syncOut)
    );

    assign pinsSync      = syncOut[7:4];
    assign resetPinSync  = syncOut[3];
    assign resetTestSync = syncOut[2];
    assign irqHighSync   = syncOut[1];
    assign irqTestSync   = syncOut[0];

    assign vectorBlank = (vectorHigh == ERASED_BYTE) && (vectorLow == ERASED_BYTE);

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_mode    = mode_ff;
        nxt_illegal = 1'b0;
        case (state_ff)
            ST_HOLD:
            begin
                if (resetPinSync)
                    nxt_state = ST_LATCH;
            end
            ST_LATCH:
            begin
                nxt_state = ST_RUN;
                // Blank-vector monitor survives a pin reset; only power-on exits it
                if (!(mode_ff.monitorMode && mode_ff.blankEntry))
                begin
                    nxt_mode = MODE_RESET;
                    // test voltage on interrupt pin, PLL off
                    if (irqTestSync)
                    begin
                        nxt_mode.monitorMode = 1'b1;
                        nxt_mode.testEntry   = 1'b1;
                        // serial pin level picks link type
                        nxt_mode.serialComm  = pinsSync.serialCommPin;
                        nxt_mode.busSrc      = pinsSync.dividerSelectPin ? BUS_DIV4 : BUS_DIV2;
                    end
                    // blank vector with test voltage on reset pin
                    else if (vectorBlank && resetTestSync)
                    begin
                        nxt_mode.busSrc = BUS_DIV4;
                        nxt_illegal     = 1'b1;
                    end
                    // PLL or plain blank entry only with blank vector
                    else if (vectorBlank)
                    begin
                        // port pins ignored, serial link forced
                        nxt_mode.monitorMode = 1'b1;
                        nxt_mode.blankEntry  = 1'b1;
                        nxt_mode.serialComm  = 1'b1;
                        // interrupt pin picks divided oscillator or PLL
                        nxt_mode.pllEnable   = !irqHighSync;
                        nxt_mode.busSrc      = irqHighSync ? BUS_DIV4 : BUS_PLL_DIV4;
                    end
                    else
                        nxt_mode.busSrc = BUS_DIV4;
                end
            end
            ST_RUN:
            begin
                if (!resetPinSync)
                    nxt_state = ST_HOLD;
            end
            default:
                nxt_state = ST_HOLD;
        endcase
    end

    always_comb
    begin
        nxt_wdog = 1'b0;
        if (state_ff == ST_RUN && resetPinSync)
        begin
            if (mode_ff.blankEntry)
                nxt_wdog = 1'b0;
            // Test-voltage monitor: disabled while test voltage on either pin
            else if (mode_ff.testEntry)
                nxt_wdog = !(irqTestSync || resetTestSync);
            else
                nxt_wdog = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff   <= ST_HOLD;
            mode_ff    <= MODE_RESET;
            illegal_ff <= 1'b0;
            wdog_ff    <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            mode_ff    <= nxt_mode;
            illegal_ff <= nxt_illegal;
            wdog_ff    <= nxt_wdog;
        end
    end

    // divider stopped unless running with reset pin high
    assign divRun    = (state_ff == ST_RUN) && resetPinSync && (mode_ff.busSrc != BUS_STOP);
    // PLL path counts PLL ticks, others count oscillator cycles
    assign divTickIn = (mode_ff.busSrc == BUS_PLL_DIV4) ? pllOutputTick : 1'b1;
    // bypass leaves only the final divide-by-two
    assign divRatio  = (mode_ff.busSrc == BUS_DIV2) ? RATIO_HALF : RATIO_QUARTER;

    bus_clk_div #(
        .CNT_W   (3)
    ) u_bus_clk_div (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (divRun),
        .tickIn  (divTickIn),
        .ratio   (divRatio),
        .tick    (busClockEnable)
    );

    assign monitorMode         = mode_ff.monitorMode;
    assign serialComm          = mode_ff.serialComm;
    assign pllEnable           = mode_ff.pllEnable;
    assign baseClockSelect     = mode_ff.pllEnable;
    // clock generator output follows oscillator clock
    assign oscBypass           = mode_ff.testEntry && (mode_ff.busSrc == BUS_DIV2);
    // test-voltage entry needs an outside oscillator
    assign crystalOscEnable    = !mode_ff.testEntry;
    assign watchdogEnable      = wdog_ff;
    assign illegalAddressReset = illegal_ff;
    // drive low only; a one releases to the pullup
    assign serialPinOut        = 1'b0;
    assign serialPinOe         = mode_ff.monitorMode && mode_ff.serialComm && !serialTxBit;

    // Checks

    a_hold_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_HOLD) |=> !busClockEnable && !watchdogEnable
    ) else $error("bus or watchdog active in hold");

    a_latch_on_edge: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_HOLD && resetPinSync) |=> (state_ff == ST_LATCH) ##1 (state_ff == ST_RUN)
    ) else $error("decision not latched after reset pin rise");

    a_blank_exact: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && !vectorBlank && !mode_ff.blankEntry) |=> !mode_ff.blankEntry
    ) else $error("programmed vector taken as blank");

    a_pll_entry: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && vectorBlank && !irqTestSync && !irqHighSync && !resetTestSync && !mode_ff.blankEntry)
        |=> mode_ff.pllEnable && mode_ff.monitorMode && (mode_ff.busSrc == BUS_PLL_DIV4)
    ) else $error("PLL monitor entry not taken");

    a_blank_no_wdog: assert property (
        @(posedge clk) disable iff (!reset_n)
        mode_ff.blankEntry |-> !watchdogEnable
    ) else $error("watchdog on after blank-vector entry");

    a_half_rate: assert property (
        @(posedge clk) disable iff (!reset_n || !divRun)
        (busClockEnable && mode_ff.busSrc == BUS_DIV2) |=> !busClockEnable ##1 busClockEnable
    ) else $error("bus enable not every second cycle");

    a_quarter_rate: assert property (
        @(posedge clk) disable iff (!reset_n || !divRun)
        (busClockEnable && mode_ff.busSrc == BUS_DIV4) |=> !busClockEnable [*3] ##1 busClockEnable
    ) else $error("bus enable not every fourth cycle");

    a_illegal_reset: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && !mode_ff.blankEntry && !irqTestSync && vectorBlank && resetTestSync)
        |=> illegalAddressReset && !monitorMode ##1 !illegalAddressReset
    ) else $error("illegal address reset not raised once");

    a_user_default: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && !irqTestSync && !vectorBlank && !mode_ff.blankEntry)
        |=> !monitorMode ##1 (watchdogEnable || !resetPinSync)
    ) else $error("user mode defaults not applied");

    a_wired_or: assert property (
        @(posedge clk) disable iff (!reset_n)
        serialPinOe |-> !serialPinOut && monitorMode && !serialTxBit
    ) else $error("serial pin driven other than low");

    a_pin_low_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_RUN && !resetPinSync) |=> !watchdogEnable && !busClockEnable
    ) else $error("bus or watchdog active with reset pin low");

    a_pll_needs_blank: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && !vectorBlank && !mode_ff.blankEntry) |=> !pllEnable && !baseClockSelect
    ) else $error("PLL enabled with programmed vector");

    a_blank_ignores_pins: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && vectorBlank && !irqTestSync && !resetTestSync && !mode_ff.blankEntry)
        |=> serialComm && !oscBypass && (mode_ff.busSrc != BUS_DIV2)
    ) else $error("blank-vector entry used port pins");

    a_test_entry_osc: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && irqTestSync && !mode_ff.blankEntry)
        |=> monitorMode && !crystalOscEnable && !pllEnable
    ) else $error("test-voltage entry kept crystal or PLL");

    a_blank_kept: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_LATCH && mode_ff.blankEntry) |=> monitorMode && mode_ff.blankEntry && !watchdogEnable
    ) else $error("blank-vector monitor lost on pin reset");

    a_test_wdog_off: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == ST_RUN && mode_ff.testEntry && irqTestSync) |=> !watchdogEnable
    ) else $error("watchdog on while test voltage applied");

endmodule : monitor_mode_entry_select

// ===== include/monitor_entry_pkg.sv
/*
 * Constants, enumerations and carrier structs for the monitor/user mode
 * entry decoder. Assumes a single 40 MHz clock domain; frequencies are
 * kept in hertz so derived ratios stay exact integers.
 */
package monitor_entry_pkg;

    // Value of an erased vector byte
    localparam logic [7:0] ERASED_BYTE      = 8'hff;

    // Clock plan, in hertz
    localparam int         CLK_HZ           = 40000000;
    localparam int         EXT_HV_LOW_HZ    = 4915200;
    localparam int         EXT_HV_HIGH_HZ   = 9830400;
    localparam int         EXT_BLANK_HZ     = 9830400;
    localparam int         CRYSTAL_HZ       = 32768;
    localparam int         MON_BUS_HZ       = 2457600;
    localparam int         MON_BAUD         = 9600;
    localparam int         BUS_PER_BIT      = MON_BUS_HZ / MON_BAUD;

    // Divider ratios of the bus clock enable
    localparam logic [2:0] RATIO_HALF       = 3'h2;
    localparam logic [2:0] RATIO_QUARTER    = 3'h4;

    typedef enum logic [1:0] {
        BUS_DIV2     = 2'h0,
        BUS_DIV4     = 2'h1,
        BUS_PLL_DIV4 = 2'h3,
        BUS_STOP     = 2'h2
    } bus_src_t;

    // Gray along hold -> latch -> run
    typedef enum logic [1:0] {
        ST_HOLD  = 2'h0,
        ST_LATCH = 2'h1,
        ST_RUN   = 2'h3
    } entry_state_t;

    typedef struct packed {
        logic serialCommPin;
        logic portAEntryPinOne;
        logic portAEntryPinTwo;
        logic dividerSelectPin;
    } entry_pins_t;

    typedef struct packed {
        logic     monitorMode;
        logic     blankEntry;
        logic     testEntry;
        logic     pllEnable;
        logic     serialComm;
        bus_src_t busSrc;
    } mode_t;

    localparam mode_t MODE_RESET = '{monitorMode: 1'b0, blankEntry: 1'b0, testEntry: 1'b0,
                                     pllEnable: 1'b0, serialComm: 1'b0, busSrc: BUS_STOP};

endpackage : monitor_entry_pkg

// ===== core/pin_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the levels are quasi-static; no bus coherency is promised.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end
        else
        begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign pinSync = stage2_ff;

endmodule : pin_sync

// ===== core/bus_clk_div.sv
/*
 * Bus clock enable divider: counts source ticks and emits a one-cycle
 * registered enable every ratio ticks. Assumes tickIn is on clk.
 */
`timescale 1ns/1ps
module bus_clk_div #(
    parameter int CNT_W = 3
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             run,
    input  wire logic             tickIn,
    input  wire logic [CNT_W-1:0] ratio,
    output logic                  tick
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             tick_ff;
    logic             nxt_tick;

    always_comb
    begin
        nxt_count = count_ff;
        nxt_tick  = 1'b0;
        // Restart on stop so the first enable after run is a full period
        if (!run)
            nxt_count = '0;
        else if (tickIn)
        begin
            if (count_ff >= ratio - CNT_W'(1))
            begin
                nxt_count = '0;
                nxt_tick  = 1'b1;
            end
            else
                nxt_count = count_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_ff <= '0;
            tick_ff  <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            tick_ff  <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : bus_clk_div

// ===== tb/entry_host_model.sv
/*
 * Outside party of the mode entry decoder: sets the entry pins, makes a
 * behavioural PLL tick and resolves the pulled-up serial wire.
 * Assumes the bench clock and reset; the PLL tick stands still while disabled.
 */
`timescale 1ns/1ps
module entry_host_model
    import monitor_entry_pkg::*;
#(
    parameter int PLL_DIV = 3
) (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire logic                           pllEnable,
    input  wire logic                           testSetup,
    input  wire logic                           hostDriveLow,
    input  wire logic                           divSelect,
    input  wire logic [1:0]                     looseBits,
    input  wire logic                           serialPinOut,
    input  wire logic                           serialPinOe,
    output logic                                serialLine,
    output logic                                pllOutputTick,
    output monitor_entry_pkg::entry_pins_t      entryPins
);
    import monitor_entry_pkg::*;

    logic [7:0] pllCount;

    // pullup unless a party pulls low
    assign serialLine = !((serialPinOe && !serialPinOut) || hostDriveLow);

    // port pins set for test-voltage entry
    always_comb
    begin
        entryPins.serialCommPin    = serialLine;
        entryPins.portAEntryPinOne = testSetup ? 1'b1 : looseBits[0];
        entryPins.portAEntryPinTwo = testSetup ? 1'b0 : looseBits[1];
        entryPins.dividerSelectPin = divSelect;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pllCount      <= 8'h00;
            pllOutputTick <= 1'b0;
        end
        else
        begin
            pllOutputTick <= pllEnable && (pllCount == 8'(PLL_DIV - 1));
            pllCount      <= (!pllEnable || pllCount == 8'(PLL_DIV - 1)) ? 8'h00 : pllCount + 8'h01;
        end
    end
endmodule : entry_host_model

// ===== tb/test_monitor_mode_entry_select.sv
/*
 * Self-checking bench for the mode entry decoder: walks each entry case
 * and compares the ports with a small reference model.
 * Assumes the host model supplies pins, PLL ticks and the serial wire.
 */
`timescale 1ns/1ps
module test_monitor_mode_entry_select;
    import monitor_entry_pkg::*;

    localparam int         PLL_DIV = 3;
    localparam int         LIMIT   = 200;
    localparam logic [8:0] IRQ_T   = 9'b100000011;
    localparam logic [8:0] IRQ_H   = 9'b110110101;
    localparam logic [8:0] RST_T   = 9'b000010010;
    localparam logic [8:0] VEC_BL  = 9'b000011100;
    localparam logic [8:0] VEC_HF  = 9'b010000000;
    localparam logic [8:0] DIV     = 9'b000000010;
    localparam logic [8:0] PAR     = 9'b100000000;

    logic        clk, reset_n, resetPinHigh, resetTestHigh, irqPinHigh, irqTestHigh;
    logic        serialTxBit, testSetup, hostDriveLow, divSelect;
    logic [1:0]  looseBits;
    logic [7:0]  vectorHigh, vectorLow;
    logic        monitorMode, serialComm, pllEnable, baseClockSelect, oscBypass;
    logic        crystalOscEnable, busClockEnable, watchdogEnable, illegalAddressReset;
    logic        serialPinOut, serialPinOe, serialLine, pllOutputTick;
    entry_pins_t entryPins;
    int          numErrors = 0;
    int          checked   = 0;
    int          busCount  = 0;
    int          illCount  = 0;

    monitor_mode_entry_select dut (.clk(clk), .reset_n(reset_n), .resetPinHigh(resetPinHigh),
        .resetTestHigh(resetTestHigh), .irqPinHigh(irqPinHigh), .irqTestHigh(irqTestHigh),
        .entryPins(entryPins), .vectorHigh(vectorHigh), .vectorLow(vectorLow),
        .pllOutputTick(pllOutputTick), .serialTxBit(serialTxBit), .monitorMode(monitorMode),
        .serialComm(serialComm), .pllEnable(pllEnable), .baseClockSelect(baseClockSelect),
        .oscBypass(oscBypass), .crystalOscEnable(crystalOscEnable), .busClockEnable(busClockEnable),
        .watchdogEnable(watchdogEnable), .illegalAddressReset(illegalAddressReset),
        .serialPinOut(serialPinOut), .serialPinOe(serialPinOe));

    entry_host_model #(.PLL_DIV(PLL_DIV)) host (.clk(clk), .reset_n(reset_n), .pllEnable(pllEnable),
        .testSetup(testSetup), .hostDriveLow(hostDriveLow), .divSelect(divSelect),
        .looseBits(looseBits), .serialPinOut(serialPinOut), .serialPinOe(serialPinOe),
        .serialLine(serialLine), .pllOutputTick(pllOutputTick), .entryPins(entryPins));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (busClockEnable === 1'b1)
            busCount <= busCount + 1;
        if (illegalAddressReset === 1'b1)
            illCount <= illCount + 1;
    end

    task automatic completeRun();
        $display("checks %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : completeRun

    task automatic check(input string what, input logic [15:0] expv, input logic [15:0] gotv);
        checked++;
        if (gotv !== expv)
        begin
            numErrors++;
            $display("mismatch %s expected %0h seen %0h", what, expv, gotv);
        end
    endtask : check

    // Cycles between two bus enable pulses
    task automatic busPeriod(output int p);
        int n;
        n = 0;
        while (busClockEnable !== 1'b1 && n < LIMIT)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        p = 1;
        while (busClockEnable !== 1'b1 && p < LIMIT)
        begin
            @(posedge clk);
            p++;
        end
        if (n >= LIMIT || p >= LIMIT)
        begin
            numErrors++;
            $display("mismatch busClockEnable expected pulse seen none");
            completeRun();
        end
    endtask : busPeriod

    task automatic runCase(input int i);
        int   b0, il0, per, eIll, ePer;
        logic eMon, ePll, eByp, eXtal, eWdg, eSer;
        eMon = 1'b0;
        ePll = 1'b0;
        eByp = 1'b0;
        eXtal = 1'b1;
        eWdg = 1'b1;
        eSer = 1'b1;
        eIll = 0;
        ePer = 4;
        if (IRQ_T[i])
        begin
            eMon = 1'b1;
            eByp = !DIV[i];
            eXtal = 1'b0;
            eWdg = 1'b0;
            eSer = !PAR[i];
            ePer = DIV[i] ? 4 : 2;
        end
        else if (VEC_BL[i] && RST_T[i])
            eIll = 1;
        else if (VEC_BL[i])
        begin
            eMon = 1'b1;
            ePll = !IRQ_H[i];
            eWdg = 1'b0;
            ePer = IRQ_H[i] ? 4 : 4 * PLL_DIV;
        end
        @(posedge clk);
        reset_n <= 1'b0;
        resetPinHigh <= 1'b0;
        irqTestHigh <= IRQ_T[i];
        irqPinHigh <= IRQ_H[i];
        resetTestHigh <= RST_T[i];
        testSetup <= IRQ_T[i];
        hostDriveLow <= PAR[i];
        divSelect <= IRQ_T[i] ? DIV[i] : 1'($urandom);
        looseBits <= 2'($urandom);
        vectorHigh <= (VEC_BL[i] || VEC_HF[i]) ? 8'hff : 8'($urandom);
        vectorLow <= VEC_BL[i] ? 8'hff : (8'($urandom) & 8'hfe);
        serialTxBit <= 1'b1;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        b0 = busCount;
        repeat (8) @(posedge clk);
        check("watchdogHold", 16'h0, 16'(watchdogEnable));
        check("busHold", 16'h0, 16'(busCount - b0));
        il0 = illCount;
        resetPinHigh <= 1'b1;
        repeat (10) @(posedge clk);
        check("monitorMode", 16'(eMon), 16'(monitorMode));
        check("pllEnable", 16'(ePll), 16'(pllEnable));
        check("baseClockSelect", 16'(ePll), 16'(baseClockSelect));
        check("oscBypass", 16'(eByp), 16'(oscBypass));
        check("crystalOscEnable", 16'(eXtal), 16'(crystalOscEnable));
        check("watchdogEnable", 16'(eWdg), 16'(watchdogEnable));
        check("illegalAddressReset", 16'(eIll), 16'(illCount - il0));
        if (eMon)
            check("serialComm", 16'(eSer), 16'(serialComm));
        busPeriod(per);
        check("busPeriod", 16'(ePer), 16'(per));
        divSelect <= ~divSelect;
        looseBits <= 2'($urandom);
        vectorLow <= 8'($urandom);
        repeat (6) @(posedge clk);
        check("monitorHeld", 16'(eMon), 16'(monitorMode));
        check("bypassHeld", 16'(eByp), 16'(oscBypass));
        busPeriod(per);
        check("periodHeld", 16'(ePer), 16'(per));
        if (eMon && eSer)
        begin
            serialTxBit <= 1'b0;
            repeat (3) @(posedge clk);
            check("serialLineLow", 16'h0, 16'(serialLine));
            serialTxBit <= 1'b1;
            repeat (3) @(posedge clk);
            check("serialLineHigh", 16'h1, 16'(serialLine));
        end
        if (eMon && VEC_BL[i])
        begin
            resetPinHigh <= 1'b0;
            repeat (6) @(posedge clk);
            resetTestHigh <= 1'b1;
            resetPinHigh <= 1'b1;
            repeat (10) @(posedge clk);
            check("blankMonitorKept", 16'h1, 16'(monitorMode));
            check("blankWatchdogOff", 16'h0, 16'(watchdogEnable));
        end
    endtask : runCase

    initial
    begin
        reset_n = 1'b0;
        resetPinHigh = 1'b0;
        resetTestHigh = 1'b0;
        irqPinHigh = 1'b1;
        irqTestHigh = 1'b0;
        serialTxBit = 1'b1;
        testSetup = 1'b0;
        hostDriveLow = 1'b0;
        divSelect = 1'b0;
        looseBits = 2'h0;
        vectorHigh = 8'hff;
        vectorLow = 8'hff;
        void'($urandom(86108));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            runCase(i);
        completeRun();
    end
endmodule : test_monitor_mode_entry_select
